// *** design/tmc_defs.svh ***
// tmc_defs.svh: offsets, bit positions, reset values and timing counts
// assumes: included by bare name into the timer/counter design files
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define TMC_CLK_PERIOD_NS 50
`define TMC_PER_DIV 6

// ****************************************************************
// control register bit positions
// ****************************************************************
`define TMC_CTL_IT0 0
`define TMC_CTL_IE0 1
`define TMC_CTL_IT1 2
`define TMC_CTL_IE1 3
`define TMC_CTL_TR0 4
`define TMC_CTL_TF0 5
`define TMC_CTL_TR1 6
`define TMC_CTL_TF1 7

// ****************************************************************
// mode register fields and count byte selects
// ****************************************************************
`define TMC_MOD_T0_LSB 0
`define TMC_MOD_T1_LSB 4
`define TMC_SEL_LOW0 2'h0
`define TMC_SEL_HIGH0 2'h1
`define TMC_SEL_LOW1 2'h2
`define TMC_SEL_HIGH1 2'h3

// ****************************************************************
// reset values
// ****************************************************************
`define TMC_CTL_RST 8'h00
`define TMC_MOD_RST 8'h00
`define TMC_CNT_RST 16'h0000

`endif

// *** design/tmc_fall_det.sv ***
// tmc_fall_det.sv: samples a count pin once per peripheral cycle
// assumes: pin is synchronous to clk; per_tick is a one-cycle strobe
`timescale 1ns/10ps
module tmc_fall_det
  import tmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic per_tick,
  input wire logic pin,
  output logic fall
);

  logic smp_reg;

  // ****************************************************************
  // high sample followed by low sample gives one count
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      smp_reg <= 1'b0;
      fall <= 1'b0;
    end else begin
      fall <= per_tick & smp_reg & ~pin;
      if (per_tick) begin
        smp_reg <= pin;
      end
    end
  end

endmodule : tmc_fall_det

// *** design/tmc_pkg.sv ***
// tmc_pkg.sv: types shared by the timer/counter design files
// assumes: compiled before every module that imports it
package tmc_pkg;

  // ****************************************************************
  // operating modes
  // ****************************************************************
  typedef enum logic [1:0] {
    TMC_M13 = 2'b00,
    TMC_M16 = 2'b01,
    TMC_M8R = 2'b10,
    TMC_MSPLIT = 2'b11
  } tmc_mode_t;

  // ****************************************************************
  // per-timer nibble of the mode register and count pair
  // ****************************************************************
  typedef struct packed {
    logic gate;
    logic ctr;
    tmc_mode_t mode;
  } tmc_cfg_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } tmc_cnt_t;

  typedef struct packed {
    tmc_cnt_t cnt;
    logic ovf;
  } tmc_step_t;

endpackage : tmc_pkg

// *** design/tmc_tick_gen.sv ***
// tmc_tick_gen.sv: timer clock select and peripheral-cycle strobe
// assumes: clk is the oscillator clock; selects are synchronous levels
`timescale 1ns/10ps
`include "tmc_defs.svh"
module tmc_tick_gen
  import tmc_pkg::*;
#(
  parameter int PER_DIV = `TMC_PER_DIV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clock_double,
  input wire logic x2_mode,
  output logic per_tick
);

  localparam int CW = $clog2(PER_DIV);
  localparam logic [CW-1:0] LAST = CW'(PER_DIV - 1);

  generate
    if (PER_DIV < 2) begin : g_chk
      $error("tmc_tick_gen: PER_DIV must be at least 2");
    end
  endgenerate

  logic half_reg;
  logic [CW-1:0] div_reg;
  logic tclk_en;

  // ****************************************************************
  // timer clock: osc/2 when doubled or standard, osc in x2 mode
  // ****************************************************************
  assign tclk_en = (clock_double | ~x2_mode) ? half_reg : 1'b1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
    end
  end

  // ****************************************************************
  // six timer clocks make one peripheral cycle
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_reg <= '0;
      per_tick <= 1'b0;
    end else begin
      per_tick <= tclk_en && (div_reg == LAST);
      if (tclk_en) begin
        div_reg <= (div_reg == LAST) ? '0 : div_reg + CW'(1);
      end
    end
  end

endmodule : tmc_tick_gen

// *** design/tmc_timers.sv ***
// tmc_timers.sv: two 16-bit timer/counters with control and mode regs
// assumes: software strobes are one-cycle pulses synchronous to clk;
// count and gate pins are synchronous levels
`timescale 1ns/10ps
`include "tmc_defs.svh"

module tmc_timers
  import tmc_pkg::*;
#(
  parameter int PER_DIV = `TMC_PER_DIV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic x2_mode,
  input wire logic timer0_clock_double,
  input wire logic timer1_clock_double,
  input wire logic count_pin0,
  input wire logic count_pin1,
  input wire logic external_interrupt_pin0,
  input wire logic external_interrupt_pin1,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  input wire logic mod_wr,
  input wire logic [7:0] mod_wdata,
  input wire logic cnt_wr,
  input wire logic [1:0] cnt_sel,
  input wire logic [7:0] cnt_wdata,
  input wire logic timer0_irq_ack,
  input wire logic timer1_irq_ack,
  input wire logic ext0_irq_ack,
  input wire logic ext1_irq_ack,
  output logic [7:0] timer_control_register,
  output logic [7:0] timer_mode_register,
  output tmc_cnt_t timer0_count,
  output tmc_cnt_t timer1_count,
  output logic timer0_irq,
  output logic timer1_irq
);

  generate
    if (PER_DIV < 2) begin : g_chk
      $error("tmc_timers: PER_DIV must be at least 2");
    end
  endgenerate

  // ****************************************************************
  // one counting step for the selected mode
  // ****************************************************************
  function automatic tmc_step_t step(input tmc_mode_t m, input tmc_cnt_t c);
    tmc_step_t r;
    r.cnt = c;
    r.ovf = 1'b0;
    unique case (m)
      TMC_M13: begin
        r.cnt.lo[4:0] = c.lo[4:0] + 5'h01;
        if (c.lo[4:0] == 5'h1F) begin
          r.cnt.hi = c.hi + 8'h01;
          r.ovf = (c.hi == 8'hFF);
        end
      end
      TMC_M16: begin
        {r.ovf, r.cnt} = {1'b0, c} + 17'h00001;
      end
      TMC_M8R: begin
        if (c.lo == 8'hFF) begin
          r.cnt.lo = c.hi;
          r.ovf = 1'b1;
        end else begin
          r.cnt.lo = c.lo + 8'h01;
        end
      end
      TMC_MSPLIT: begin
        {r.ovf, r.cnt.lo} = {1'b0, c.lo} + 9'h001;
      end
    endcase
    return r;
  endfunction : step

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] ctl_reg;
  logic [7:0] mod_reg;
  tmc_cnt_t cnt0_reg;
  tmc_cnt_t cnt1_reg;
  tmc_cnt_t cnt0_next;
  tmc_cnt_t cnt1_next;
  logic [1:0] int_prev_reg;

  tmc_cfg_t cfg0;
  tmc_cfg_t cfg1;
  tmc_step_t st0;
  tmc_step_t st1;
  logic [1:0] tick;
  logic [1:0] fall;
  logic split;
  logic run0;
  logic run1;
  logic inc0;
  logic inc0h;
  logic inc1;
  logic set_tf0;
  logic set_tf1;
  logic set_ie0;
  logic set_ie1;

  // ****************************************************************
  // clock strobes and pin samplers, one per timer
  // ****************************************************************
  logic [1:0] clk_dbl;
  logic [1:0] cpin;
  assign clk_dbl = {timer1_clock_double, timer0_clock_double};
  assign cpin = {count_pin1, count_pin0};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_tmr
      tmc_tick_gen #(
        .PER_DIV(PER_DIV)
      ) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .clock_double(clk_dbl[i]),
        .x2_mode(x2_mode),
        .per_tick(tick[i])
      );
      tmc_fall_det u_fall (
        .clk(clk),
        .rst_b(rst_b),
        .per_tick(tick[i]),
        .pin(cpin[i]),
        .fall(fall[i])
      );
    end
  endgenerate

  // ****************************************************************
  // configuration decode
  // ****************************************************************
  assign cfg0 = tmc_cfg_t'(mod_reg[`TMC_MOD_T0_LSB +: 4]);
  assign cfg1 = tmc_cfg_t'(mod_reg[`TMC_MOD_T1_LSB +: 4]);
  assign split = (cfg0.mode == TMC_MSPLIT);

  // ****************************************************************
  // run and gate logic
  // ****************************************************************
  assign run0 = ctl_reg[`TMC_CTL_TR0] &
                (~cfg0.gate | external_interrupt_pin0);
  assign inc0 = run0 & (cfg0.ctr ? fall[0] : tick[0]);
  assign inc0h = split & ctl_reg[`TMC_CTL_TR1] & tick[0];

  // timer 1 runs without its run bit while timer 0 is split
  assign run1 = (split | ctl_reg[`TMC_CTL_TR1]) &
                (~cfg1.gate | external_interrupt_pin1) &
                (cfg1.mode != TMC_MSPLIT);
  assign inc1 = run1 & (cfg1.ctr ? fall[1] : tick[1]);

  assign st0 = step(cfg0.mode, cnt0_reg);
  assign st1 = step(cfg1.mode, cnt1_reg);

  // ****************************************************************
  // overflow events
  // ****************************************************************
  assign set_tf0 = inc0 & st0.ovf;
  assign set_tf1 = split ? (inc0h & (cnt0_reg.hi == 8'hFF))
                         : (inc1 & st1.ovf);

  // ****************************************************************
  // external interrupt flags: edge or level per type bit
  // ****************************************************************
  assign set_ie0 = ctl_reg[`TMC_CTL_IT0] ?
                   (int_prev_reg[0] & ~external_interrupt_pin0) :
                   ~external_interrupt_pin0;
  assign set_ie1 = ctl_reg[`TMC_CTL_IT1] ?
                   (int_prev_reg[1] & ~external_interrupt_pin1) :
                   ~external_interrupt_pin1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      int_prev_reg <= 2'h3;
    end else begin
      int_prev_reg <= {external_interrupt_pin1, external_interrupt_pin0};
    end
  end

  // ****************************************************************
  // next count values: counting, then software writes
  // ****************************************************************
  always_comb begin
    cnt0_next = cnt0_reg;
    if (inc0) begin
      cnt0_next = st0.cnt;
    end
    if (inc0h) begin
      cnt0_next.hi = cnt0_reg.hi + 8'h01;
    end
    if (cnt_wr && (cnt_sel == `TMC_SEL_LOW0)) begin
      cnt0_next.lo = cnt_wdata;
    end
    if (cnt_wr && (cnt_sel == `TMC_SEL_HIGH0)) begin
      cnt0_next.hi = cnt_wdata;
    end
  end

  always_comb begin
    cnt1_next = cnt1_reg;
    if (inc1) begin
      cnt1_next = st1.cnt;
    end
    if (cnt_wr && (cnt_sel == `TMC_SEL_LOW1)) begin
      cnt1_next.lo = cnt_wdata;
    end
    if (cnt_wr && (cnt_sel == `TMC_SEL_HIGH1)) begin
      cnt1_next.hi = cnt_wdata;
    end
  end

  // ****************************************************************
  // count registers, untouched by the run bit itself
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt0_reg <= `TMC_CNT_RST;
    end else begin
      cnt0_reg <= cnt0_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt1_reg <= `TMC_CNT_RST;
    end else begin
      cnt1_reg <= cnt1_next;
    end
  end

  // ****************************************************************
  // mode register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mod_reg <= `TMC_MOD_RST;
    end else if (mod_wr) begin
      mod_reg <= mod_wdata;
    end
  end

  // ****************************************************************
  // control register: run and type bits from software
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_reg[`TMC_CTL_IT0] <= 1'b0;
      ctl_reg[`TMC_CTL_IT1] <= 1'b0;
      ctl_reg[`TMC_CTL_TR0] <= 1'b0;
      ctl_reg[`TMC_CTL_TR1] <= 1'b0;
    end else if (ctl_wr) begin
      ctl_reg[`TMC_CTL_IT0] <= ctl_wdata[`TMC_CTL_IT0];
      ctl_reg[`TMC_CTL_IT1] <= ctl_wdata[`TMC_CTL_IT1];
      ctl_reg[`TMC_CTL_TR0] <= ctl_wdata[`TMC_CTL_TR0];
      ctl_reg[`TMC_CTL_TR1] <= ctl_wdata[`TMC_CTL_TR1];
    end
  end

  // ****************************************************************
  // flags: hardware set wins over software write and service clear
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_reg[`TMC_CTL_TF0] <= 1'b0;
    end else if (set_tf0) begin
      ctl_reg[`TMC_CTL_TF0] <= 1'b1;
    end else if (ctl_wr) begin
      ctl_reg[`TMC_CTL_TF0] <= ctl_wdata[`TMC_CTL_TF0];
    end else if (timer0_irq_ack) begin
      ctl_reg[`TMC_CTL_TF0] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_reg[`TMC_CTL_TF1] <= 1'b0;
    end else if (set_tf1) begin
      ctl_reg[`TMC_CTL_TF1] <= 1'b1;
    end else if (ctl_wr) begin
      ctl_reg[`TMC_CTL_TF1] <= ctl_wdata[`TMC_CTL_TF1];
    end else if (timer1_irq_ack) begin
      ctl_reg[`TMC_CTL_TF1] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_reg[`TMC_CTL_IE0] <= 1'b0;
    end else if (set_ie0) begin
      ctl_reg[`TMC_CTL_IE0] <= 1'b1;
    end else if (ctl_wr) begin
      ctl_reg[`TMC_CTL_IE0] <= ctl_wdata[`TMC_CTL_IE0];
    end else if (ext0_irq_ack || !ctl_reg[`TMC_CTL_IT0]) begin
      ctl_reg[`TMC_CTL_IE0] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_reg[`TMC_CTL_IE1] <= 1'b0;
    end else if (set_ie1) begin
      ctl_reg[`TMC_CTL_IE1] <= 1'b1;
    end else if (ctl_wr) begin
      ctl_reg[`TMC_CTL_IE1] <= ctl_wdata[`TMC_CTL_IE1];
    end else if (ext1_irq_ack || !ctl_reg[`TMC_CTL_IT1]) begin
      ctl_reg[`TMC_CTL_IE1] <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs, each straight from a register
  // ****************************************************************
  assign timer_control_register = ctl_reg;
  assign timer_mode_register = mod_reg;
  assign timer0_count = cnt0_reg;
  assign timer1_count = cnt1_reg;
  assign timer0_irq = ctl_reg[`TMC_CTL_TF0];
  assign timer1_irq = ctl_reg[`TMC_CTL_TF1];

endmodule : tmc_timers

// *** tb/testbench.sv ***
// testbench.sv: self-checking bench for the timer/counter block
// assumes: tmc_pkg, tmc_timers, the checker and the pin model compiled first
`timescale 1ns/10ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module testbench;
  import tmc_pkg::*;
  typedef struct packed {
    logic t, x2, dbl, g;
    logic [3:0] cfg;
    logic [7:0] hi, lo, win, ehi, elo;
    logic etf;
  } tmc_row_t;
  logic clk, rst_b, x2_mode, t0d, t1d, ctl_wr, mod_wr, cnt_wr, ack0, ack1, go, busy;
  logic [7:0] ctl_wdata, mod_wdata, cnt_wdata, timer_control_register, timer_mode_register;
  logic [1:0] cnt_sel, gate_lvl;
  logic cp0, cp1, ep0, ep1, timer0_irq, timer1_irq;
  tmc_cnt_t timer0_count, timer1_count;
  int n_mismatch = 0;
  int checked = 0;
  tmc_row_t rows [9] = '{
    '{1'h0, 1'h0, 1'h0, 1'h0, 4'h1, 8'hFF, 8'hFE, 8'h24, 8'h00, 8'h01, 1'h1},
    '{1'h0, 1'h1, 1'h0, 1'h0, 4'h1, 8'h00, 8'h10, 8'h24, 8'h00, 8'h16, 1'h0},
    '{1'h0, 1'h1, 1'h1, 1'h0, 4'h1, 8'h00, 8'h10, 8'h24, 8'h00, 8'h13, 1'h0},
    '{1'h0, 1'h0, 1'h0, 1'h0, 4'h0, 8'hFF, 8'h1E, 8'h24, 8'h00, 8'h01, 1'h1},
    '{1'h0, 1'h0, 1'h0, 1'h0, 4'h2, 8'hF0, 8'hFE, 8'h30, 8'hF0, 8'hF2, 1'h1},
    '{1'h1, 1'h0, 1'h0, 1'h0, 4'h1, 8'h7F, 8'hFF, 8'h18, 8'h80, 8'h01, 1'h0},
    '{1'h1, 1'h0, 1'h0, 1'h0, 4'h2, 8'h80, 8'hFF, 8'h18, 8'h80, 8'h81, 1'h1},
    '{1'h0, 1'h0, 1'h0, 1'h0, 4'h9, 8'h00, 8'h00, 8'h24, 8'h00, 8'h00, 1'h0},
    '{1'h0, 1'h0, 1'h0, 1'h1, 4'h9, 8'h00, 8'h00, 8'h24, 8'h00, 8'h03, 1'h0}};
  tmc_timers dut_u (.clk(clk), .rst_b(rst_b), .x2_mode(x2_mode), .timer0_clock_double(t0d),
    .timer1_clock_double(t1d), .count_pin0(cp0), .count_pin1(cp1),
    .external_interrupt_pin0(ep0), .external_interrupt_pin1(ep1), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .mod_wr(mod_wr), .mod_wdata(mod_wdata), .cnt_wr(cnt_wr),
    .cnt_sel(cnt_sel), .cnt_wdata(cnt_wdata), .timer0_irq_ack(ack0),
    .timer1_irq_ack(ack1), .ext0_irq_ack(1'h0), .ext1_irq_ack(1'h0),
    .timer_control_register(timer_control_register),
    .timer_mode_register(timer_mode_register), .timer0_count(timer0_count),
    .timer1_count(timer1_count), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq));
  tmc_pin_model pin_u (.clk(clk), .go(go), .n_falls(8'h05), .hold(8'h0C),
    .gate_lvl(gate_lvl), .count_pin0(cp0), .count_pin1(cp1),
    .external_interrupt_pin0(ep0), .external_interrupt_pin1(ep1), .busy(busy));
  // ****
  // clock, strobes and closing
  // ****
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic wr_ctl(input logic [7:0] d);
    ctl_wdata = d;
    ctl_wr = 1'h1;
    @(negedge clk);
    ctl_wr = 1'h0;
    @(negedge clk);
  endtask : wr_ctl
  task automatic wr_mod(input logic [7:0] d);
    mod_wdata = d;
    mod_wr = 1'h1;
    @(negedge clk);
    mod_wr = 1'h0;
    @(negedge clk);
  endtask : wr_mod
  task automatic wr_cnt(input logic [1:0] s, input logic [7:0] d);
    cnt_sel = s;
    cnt_wdata = d;
    cnt_wr = 1'h1;
    @(negedge clk);
    cnt_wr = 1'h0;
    @(negedge clk);
  endtask : wr_cnt
  task automatic stop(input logic [7:0] rm);
    wr_ctl(timer_control_register & ~rm);
    repeat (2) @(negedge clk);
  endtask : stop
  task automatic run_row(input tmc_row_t r);
    logic [7:0] rm;
    tmc_cnt_t c;
    rm = r.t ? 8'h40 : 8'h10;
    x2_mode = r.x2;
    t0d = r.dbl;
    t1d = r.dbl;
    gate_lvl = r.g ? 2'h3 : 2'h0;
    repeat (24) @(negedge clk);
    wr_ctl(8'h00);
    wr_mod(r.t ? {r.cfg, 4'h0} : {4'h0, r.cfg});
    wr_cnt({r.t, 1'h1}, r.hi);
    wr_cnt({r.t, 1'h0}, r.lo);
    wr_ctl(rm);
    repeat (r.win - 2) @(negedge clk);
    stop(rm);
    c = r.t ? timer1_count : timer0_count;
    `CHK(c, {r.ehi, r.elo}, "count")
    `CHK(r.t ? timer1_irq : timer0_irq, r.etf, "flag")
    $display("row done");
  endtask : run_row
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    #500000;
    n_mismatch++;
    finish_test();
  end
  // ****
  // main sequence
  // ****
  initial begin
    {rst_b, x2_mode, t0d, t1d, ctl_wr, mod_wr, cnt_wr, ack0, ack1, go} = '0;
    {ctl_wdata, mod_wdata, cnt_wdata, cnt_sel, gate_lvl} = '0;
    repeat (2) @(negedge clk);
    rst_b = 1'h1;
    `CHK(timer_control_register, 8'h00, "ctl reset")
    foreach (rows[i]) run_row(rows[i]);
    run_row(rows[0]);
    ack0 = 1'h1;
    @(negedge clk);
    ack0 = 1'h0;
    @(negedge clk);
    `CHK(timer0_irq, 1'h0, "ack clear")
    $display("ack done");
    wr_mod(8'h33);
    wr_cnt(2'h1, 8'hFE);
    wr_cnt(2'h0, 8'h10);
    wr_cnt(2'h3, 8'h12);
    wr_cnt(2'h2, 8'h34);
    wr_ctl(8'h50);
    repeat (34) @(negedge clk);
    stop(8'h50);
    `CHK(timer0_count, 16'h0113, "split count")
    `CHK(timer_control_register[7:5], 3'h4, "split flags")
    `CHK(timer1_count, 16'h1234, "timer1 halt")
    ack1 = 1'h1;
    @(negedge clk);
    ack1 = 1'h0;
    @(negedge clk);
    `CHK(timer1_irq, 1'h0, "ack1 clear")
    $display("split done");
    wr_ctl(8'h00);
    wr_mod(8'h55);
    for (int s = 0; s < 4; s++) wr_cnt(s[1:0], 8'h00);
    wr_ctl(8'h50);
    go = 1'h1;
    @(negedge clk);
    go = 1'h0;
    for (int k = 0; k < 400 && busy; k++) @(negedge clk);
    `CHK(busy, 1'h0, "pin model finished")
    repeat (30) @(negedge clk);
    stop(8'h50);
    `CHK(timer0_count, 16'h0005, "counter0")
    `CHK(timer1_count, 16'h0005, "counter1")
    $display("counter done");
    wr_ctl(8'h10);
    rst_b = 1'h0;
    repeat (2) @(negedge clk);
    rst_b = 1'h1;
    `CHK({timer_mode_register, timer0_count}, 24'h000000, "reset")
    $display("reset done");
    finish_test();
  end
endmodule : testbench

// *** tb/tmc_pin_model.sv ***
// tmc_pin_model.sv: far-side model of the count and gate pins
// assumes: go is a one-cycle level sampled on the rising clk edge
`timescale 1ns/10ps
module tmc_pin_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_falls,
  input wire logic [7:0] hold,
  input wire logic [1:0] gate_lvl,
  output logic count_pin0,
  output logic count_pin1,
  output logic external_interrupt_pin0,
  output logic external_interrupt_pin1,
  output logic busy
);
  // ****
  // gate pins follow the requested levels
  // ****
  assign external_interrupt_pin0 = gate_lvl[0];
  assign external_interrupt_pin1 = gate_lvl[1];
  // ****
  // count pins: n pulses, each level held hold clocks
  // ****
  initial begin
    count_pin0 = 1'h0;
    count_pin1 = 1'h0;
    busy = 1'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy = 1'h1;
        @(negedge clk);
        repeat (n_falls) begin
          count_pin0 = 1'h1;
          count_pin1 = 1'h1;
          repeat (hold) @(negedge clk);
          count_pin0 = 1'h0;
          count_pin1 = 1'h0;
          repeat (hold) @(negedge clk);
        end
        busy = 1'h0;
      end
    end
  end
endmodule : tmc_pin_model

// *** tb/tmc_timers_sva.sv ***
// tmc_timers_sva.sv: port checks for the timer/counter block
// assumes: bound to tmc_timers; clk rising edge, rst_b sync low
`timescale 1ns/10ps
module tmc_timers_sva
  import tmc_pkg::*;
#(
  parameter int PER_DIV = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic external_interrupt_pin0,
  input wire logic ctl_wr,
  input wire logic mod_wr,
  input wire logic [7:0] mod_wdata,
  input wire logic cnt_wr,
  input wire logic [1:0] cnt_sel,
  input wire logic [7:0] cnt_wdata,
  input wire logic [7:0] timer_control_register,
  input wire logic [7:0] timer_mode_register,
  input wire tmc_cnt_t timer0_count,
  input wire tmc_cnt_t timer1_count,
  input wire logic timer0_irq,
  input wire logic timer1_irq
);
  logic [1:0] m0;
  assign m0 = timer_mode_register[1:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****
  // assertions
  // ****
  a_irq0_flag: assert property (
    timer0_irq == timer_control_register[5] && (!$rose(timer0_irq) || $past(ctl_wr)
    || $past(timer0_count) != timer0_count || timer0_count.lo == timer0_count.hi))
    else $error("timer0 flag wrong or raised without a rollover");
  a_irq1_flag: assert property (
    timer1_irq == timer_control_register[7] && (!$rose(timer1_irq) || $past(ctl_wr)
    || $past(timer1_count) != timer1_count || $past(timer0_count.hi) != timer0_count.hi
    || timer1_count.lo == timer1_count.hi))
    else $error("timer1 flag wrong or raised without a rollover");
  a_mode_write: assert property (mod_wr |=> timer_mode_register == $past(mod_wdata))
    else $error("mode register not loaded");
  a_hi_write: assert property (
    cnt_wr && cnt_sel == 2'h1 |=> timer0_count.hi == $past(cnt_wdata))
    else $error("high byte write lost");
  a_run_hold: assert property (
    !timer_control_register[4] && m0 != 2'h3 && !cnt_wr |=> $stable(timer0_count))
    else $error("timer0 moved with run clear");
  a_gate_low: assert property (
    timer_mode_register[3] && !external_interrupt_pin0 && !$past(external_interrupt_pin0)
    && m0 != 2'h3 && !cnt_wr |=> $stable(timer0_count))
    else $error("timer0 moved with gate pin low");
  a_step_one: assert property (
    m0 == 2'h1 && !cnt_wr |=> timer0_count == $past(timer0_count)
    || timer0_count == $past(timer0_count) + 16'h0001)
    else $error("timer0 stepped by more than one");
  a_ovf_flag: assert property (
    (timer0_count == 16'hFFFF && m0 == 2'h1 && !cnt_wr) ##1 (timer0_count == 16'h0000)
    |-> timer_control_register[5])
    else $error("rollover did not set flag");
  a_reload_high: assert property (
    (m0 == 2'h2 && !cnt_wr && timer0_count.lo == 8'hFF) ##1 (timer0_count.lo != 8'hFF)
    |-> timer0_count.lo == $past(timer0_count.hi) && timer_control_register[5])
    else $error("auto-reload wrong");
  a_t1_halt: assert property (
    timer_mode_register[5:4] == 2'h3 && !cnt_wr |=> $stable(timer1_count))
    else $error("timer1 moved in mode 3");
  c_ovf0: cover property ($rose(timer0_irq));
  c_split: cover property (m0 == 2'h3 && timer_control_register[7]);
  c_reload: cover property (m0 == 2'h2 && timer0_count.lo == 8'hFF);
endmodule : tmc_timers_sva
bind tmc_timers tmc_timers_sva #(.PER_DIV(PER_DIV)) chk_u (.clk, .rst_b,
  .external_interrupt_pin0, .ctl_wr, .mod_wr, .mod_wdata, .cnt_wr, .cnt_sel, .cnt_wdata,
  .timer_control_register, .timer_mode_register, .timer0_count, .timer1_count,
  .timer0_irq, .timer1_irq);
